// >>> aspc_pkg.sv
package aspc_pkg;

  localparam logic [10:0] ADDR_ACCESS = 11'h000;
  localparam logic [10:0] ADDR_PWR    = 11'h004;
  localparam logic [10:0] ADDR_INP    = 11'h008;
  localparam logic [10:0] ADDR_OUTP   = 11'h00C;

  localparam logic [4:0] CMD_NOP = 5'h00;
  localparam logic [4:0] CMD_WR  = 5'h01;
  localparam logic [4:0] CMD_RD  = 5'h02;
  localparam logic [4:0] CMD_SET = 5'h03;
  localparam logic [4:0] CMD_CLR = 5'h04;

  localparam logic [7:0] UNLOCK_KEY = 8'hAA;
  localparam logic [7:0] RESET_VAL  = 8'h00;
  localparam logic [7:0] PWR_MASK   = 8'h1E;
  localparam logic [7:0] INP_MASK   = 8'h03;
  localparam logic [7:0] OUTP_MASK  = 8'h77;
  localparam logic [7:0] ACC_MASK   = 8'hFF;

  localparam int BIT_MIDBUF  = 4;
  localparam int BIT_REF     = 3;
  localparam int BIT_REFBUF  = 2;
  localparam int BIT_CONV    = 1;
  localparam int BIT_PFO     = 6;
  localparam int BIT_RALIGN  = 5;
  localparam int BIT_BYTE    = 4;
  localparam int BIT_DUAL    = 2;

  localparam logic [1:0] PROTO_FOLLOW  = 2'h0;
  localparam logic [1:0] PROTO_RETIMED = 2'h3;

  localparam int FRAME_BITS = 24;
  localparam logic [5:0] LEN_SHORT = 6'h10;
  localparam logic [5:0] LEN_LONG  = 6'h20;
  localparam logic [5:0] BYTE_SPLIT_SHORT = 6'h08;
  localparam logic [5:0] BYTE_SPLIT_LONG  = 6'h10;

  typedef struct packed {
    logic [4:0]  cmd;
    logic [10:0] addr;
    logic [7:0]  data;
  } aspc_frame_t;

  typedef struct packed {
    logic midscale_buffer_off;
    logic reference_off;
    logic reference_buffer_off;
    logic converter_off;
  } aspc_power_t;

  typedef struct packed {
    logic [1:0] output_protocol;
    logic [1:0] input_clock_mode;
    logic       dual_lane_output;
    logic       lane_split_by_byte;
    logic       right_aligned;
    logic       processor_friendly_output;
    logic [5:0] frame_len;
    logic [5:0] secondary_len;
  } aspc_outcfg_t;

endpackage

// >>> aspc_core.sv
// Function
// R01: After reset, configuration registers refuse writes until access control is unlocked.
// R02: Host unlocks by writing AAh to access control; other values keep lock.
// R03: A 24-bit frame of command, address and data updates on chip-select rise.
// R04: Power-down bit 4 switches off midscale buffer; reset zero.
// R05: Power-down bit 3 switches off internal reference; reset zero.
// R06: Power-down bit 2 switches off reference buffer; reset zero.
// R07: Power-down bit 1 switches off converter core; reset zero.
// R08: Converter powers down at the chip-select rise ending the write frame.
// R09: Clearing converter bit starts power-up at chip-select rise; host waits wake time.
// R10: Reference buffer shuts down at chip-select rise ending the frame.
// R11: Internal reference shuts down at chip-select rise ending the frame.
// R12: Reserved register bits always read back as zero.
// R13: Host never writes ones into reserved bit positions.
// R14: Two-bit input field picks clock polarity and phase; reset 00b.
// R15: Processor-friendly off: output frame length equals formatted length.
// R16: Processor-friendly on: pad to 16 below 16 bits, else 32; the code also gives 16 for exactly 16 bits.
// R17: Bit 5 picks left or right alignment, only in processor-friendly mode.
// R18: Bit 2 picks single lane or dual lane with secondary carrying MSB.
// R19: Bit 4 picks interleave only when friendly and dual are both on.
// R20: Lane_split_by_byte: secondary sends 8 MSBs up to 16, else 16 MSBs.
// R21: Output field 00b follows input mode; 11b selects re-timed transfer.
// R22: Host never programs output field to 01b or 10b.
// R23: While locked, write, set and clear commands leave registers unchanged.
module aspc_core #(
  parameter int DATA_LEN = 16
) (
  input  wire logic                  CLK,
  input  wire logic                  RST_N,
  input  wire logic                  CE,
  input  wire logic                  SCLK,
  input  wire logic                  CS_N,
  input  wire logic                  SDI,
  input  wire logic [5:0]            FORMAT_LEN,
  output logic                       SDO_RD,
  output logic                       WRITE_UNLOCKED,
  output aspc_pkg::aspc_power_t      POWER_OFF,
  output aspc_pkg::aspc_outcfg_t     OUT_CFG,
  output logic                       FRAME_DONE
);
  import aspc_pkg::*;

  // Link domain: shifts SDI on SCLK, only while CS_N is low.
  logic [23:0] shift_r;
  logic [4:0]  cnt_r;
  logic [7:0]  rd_shift_r;
  logic        frame_tgl_r;
  logic [23:0] frame_hold_r;
  logic [1:0]  input_clock_mode_sync_r;
  logic [1:0]  input_clock_mode_meta_r;

  // The link clock stops between frames, so the frame count is cleared by chip select itself.
  // Counting one past a full frame lets an overlong frame be refused at the chip-select rise.
  always_ff @(posedge SCLK or posedge CS_N) begin
    if (CS_N) begin
      cnt_r <= 5'h00;
    end else if (cnt_r != 5'(FRAME_BITS + 1)) begin
      cnt_r <= cnt_r + 5'h01;
    end
  end

  always_ff @(posedge SCLK or negedge RST_N) begin
    if (!RST_N) begin
      shift_r <= 24'h000000;
    end else if (!CS_N) begin
      shift_r <= {shift_r[22:0], SDI}; // R03
    end
  end

  // A complete frame is latched at the chip-select rise and announced by a toggle.
  always_ff @(posedge CS_N or negedge RST_N) begin
    if (!RST_N) begin
      frame_hold_r <= 24'h000000;
      frame_tgl_r  <= 1'b0;
    end else if (cnt_r == 5'(FRAME_BITS)) begin
      frame_hold_r <= shift_r; // R03
      frame_tgl_r  <= ~frame_tgl_r;
    end
  end

  // Read data is handed over as a word that is stable long before the next frame.
  logic [7:0] rd_word_r;
  always_ff @(posedge SCLK or negedge RST_N) begin
    if (!RST_N) begin
      rd_shift_r <= 8'h00;
    end else if (cnt_r == 5'h00) begin
      rd_shift_r <= {rd_word_r[6:0], 1'b0};
    end else begin
      rd_shift_r <= {rd_shift_r[6:0], 1'b0};
    end
  end

  // Capture-edge selection of the input clock mode is left to the pad; only mode is shown here.
  always_ff @(posedge SCLK or negedge RST_N) begin
    if (!RST_N) begin
      input_clock_mode_meta_r <= 2'h0;
      input_clock_mode_sync_r <= 2'h0;
    end else begin
      input_clock_mode_meta_r <= OUT_CFG.input_clock_mode;
      input_clock_mode_sync_r <= input_clock_mode_meta_r; // R14
    end
  end

  // System domain: three-stage sync of the frame toggle.
  logic [2:0] tgl_sync_r;
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      tgl_sync_r <= 3'h0;
    end else if (CE) begin
      tgl_sync_r <= {tgl_sync_r[1:0], frame_tgl_r};
    end
  end

  logic        frame_evt;
  logic        evt_d_r;
  aspc_frame_t frm;
  assign frame_evt = tgl_sync_r[2] ^ tgl_sync_r[1];
  assign frm       = aspc_frame_t'(frame_hold_r);

  // The done pulse waits one cycle so that it lines up with the registered outputs.
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      evt_d_r <= 1'b0;
    end else if (CE) begin
      evt_d_r <= frame_evt; // R03
    end
  end

  function automatic logic [7:0] apply_cmd(input logic [4:0] cmd, input logic [7:0] old,
                                           input logic [7:0] dat, input logic [7:0] mask);
    logic [7:0] res;
    res = old;
    case (cmd)
      CMD_WR:  res = dat;
      CMD_SET: res = old | dat;
      CMD_CLR: res = old & ~dat;
      default: res = old;
    endcase
    return res & mask; // R12
  endfunction

  logic [7:0] access_r;
  logic [7:0] pwr_r;
  logic [7:0] inp_r;
  logic [7:0] outp_r;
  logic       unlocked;
  assign unlocked = (access_r == UNLOCK_KEY); // R01 R02

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      access_r <= RESET_VAL;
    end else if (CE && frame_evt && frm.addr == ADDR_ACCESS) begin
      access_r <= apply_cmd(frm.cmd, access_r, frm.data, ACC_MASK);
    end
  end

  // Locked writes are dropped silently; the host sees nothing but unchanged read-back.
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      pwr_r  <= RESET_VAL; // R04 R05 R06 R07
      inp_r  <= RESET_VAL; // R14
      outp_r <= RESET_VAL;
    end else if (CE && frame_evt && unlocked) begin // R23
      if (frm.addr == ADDR_PWR) begin
        pwr_r <= apply_cmd(frm.cmd, pwr_r, frm.data, PWR_MASK); // R08 R09 R10 R11
      end
      if (frm.addr == ADDR_INP) begin
        inp_r <= apply_cmd(frm.cmd, inp_r, frm.data, INP_MASK);
      end
      if (frm.addr == ADDR_OUTP) begin
        outp_r <= apply_cmd(frm.cmd, outp_r, frm.data, OUTP_MASK);
      end
    end
  end

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      rd_word_r <= 8'h00;
    end else if (CE && frame_evt && frm.cmd == CMD_RD) begin
      case (frm.addr)
        ADDR_ACCESS: rd_word_r <= access_r;
        ADDR_PWR:    rd_word_r <= pwr_r;
        ADDR_INP:    rd_word_r <= inp_r;
        ADDR_OUTP:   rd_word_r <= outp_r;
        default:     rd_word_r <= 8'h00;
      endcase
    end
  end

  // Frame length and lane split follow the output configuration.
  function automatic logic [5:0] frame_len(input logic pfo, input logic [5:0] n);
    if (!pfo) begin
      return n; // R15
    end
    return (n <= LEN_SHORT) ? LEN_SHORT : LEN_LONG; // R16
  endfunction

  logic [5:0] len_c;
  logic [5:0] sec_c;
  logic       pfo_c;
  logic       dual_c;
  logic       byte_c;
  always_comb begin
    pfo_c  = outp_r[BIT_PFO];
    dual_c = outp_r[BIT_DUAL]; // R18
    byte_c = pfo_c && dual_c && outp_r[BIT_BYTE]; // R19
    len_c  = frame_len(pfo_c, FORMAT_LEN);
    if (!dual_c) begin
      sec_c = 6'h00;
    end else if (byte_c) begin
      sec_c = (FORMAT_LEN <= LEN_SHORT) ? BYTE_SPLIT_SHORT : BYTE_SPLIT_LONG; // R20
    end else begin
      sec_c = (len_c + 6'h01) >> 1;
    end
  end

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      POWER_OFF      <= '0;
      OUT_CFG        <= '0;
      WRITE_UNLOCKED <= 1'b0;
      FRAME_DONE     <= 1'b0;
    end else if (CE) begin
      POWER_OFF.midscale_buffer_off  <= pwr_r[BIT_MIDBUF];
      POWER_OFF.reference_off        <= pwr_r[BIT_REF];
      POWER_OFF.reference_buffer_off <= pwr_r[BIT_REFBUF];
      POWER_OFF.converter_off        <= pwr_r[BIT_CONV];
      OUT_CFG.output_protocol        <= outp_r[1:0]; // R21
      OUT_CFG.input_clock_mode       <= inp_r[1:0];
      OUT_CFG.dual_lane_output       <= dual_c;
      OUT_CFG.lane_split_by_byte     <= byte_c;
      OUT_CFG.right_aligned          <= pfo_c && outp_r[BIT_RALIGN]; // R17
      OUT_CFG.processor_friendly_output <= pfo_c;
      OUT_CFG.frame_len              <= len_c;
      OUT_CFG.secondary_len          <= sec_c;
      WRITE_UNLOCKED                 <= unlocked;
      FRAME_DONE                     <= evt_d_r; // R03
    end
  end

  always_ff @(posedge SCLK or negedge RST_N) begin
    if (!RST_N) begin
      SDO_RD <= 1'b0;
    end else begin
      SDO_RD <= (cnt_r == 5'h00) ? rd_word_r[7] : rd_shift_r[7];
    end
  end

endmodule

// >>> aspc_core_assertions.sv
module aspc_core_chk
  import aspc_pkg::*;
#(
  parameter int DATA_LEN = 16
) (
  input wire logic                  CLK,
  input wire logic                  RST_N,
  input wire logic                  CS_N,
  input wire logic [5:0]            FORMAT_LEN,
  input wire logic                  WRITE_UNLOCKED,
  input wire aspc_pkg::aspc_power_t  POWER_OFF,
  input wire aspc_pkg::aspc_outcfg_t OUT_CFG,
  input wire logic                  FRAME_DONE
);
  default clocking @(posedge CLK); endclocking
  default disable iff (!RST_N);
  logic [5:0] len_exp;
  logic [5:0] sec_exp;
  always_comb begin
    len_exp = FORMAT_LEN;
    if (OUT_CFG.processor_friendly_output) begin
      len_exp = (FORMAT_LEN > LEN_SHORT) ? LEN_LONG : LEN_SHORT;
    end
    sec_exp = (OUT_CFG.frame_len + 6'h01) >> 1;
    if (!OUT_CFG.dual_lane_output) begin
      sec_exp = 6'h00;
    end else if (OUT_CFG.processor_friendly_output && OUT_CFG.lane_split_by_byte) begin
      sec_exp = (OUT_CFG.frame_len > LEN_SHORT) ? BYTE_SPLIT_LONG : BYTE_SPLIT_SHORT;
    end
  end
  // Derived lengths may trail the register update, so they are judged once settled.
  sequence s_settled;
    FRAME_DONE ##3 1'b1;
  endsequence
  property p_pwr_at_done; $changed(POWER_OFF) |-> FRAME_DONE; endproperty
  a_pwr_at_done: assert property (p_pwr_at_done) else $error("power moved off a frame");
  property p_done_pulse; FRAME_DONE |=> !FRAME_DONE; endproperty
  a_done_pulse: assert property (p_done_pulse) else $error("done not a pulse");
  property p_done_cs; FRAME_DONE |-> CS_N && $past(CS_N, 2); endproperty
  a_done_cs: assert property (p_done_cs) else $error("done inside a frame");
  property p_lock_pwr; !$past(WRITE_UNLOCKED) |-> $stable(POWER_OFF); endproperty
  a_lock_pwr: assert property (p_lock_pwr) else $error("locked power changed");
  property p_lock_mode; !$past(WRITE_UNLOCKED) |-> $stable(OUT_CFG.input_clock_mode); endproperty
  a_lock_mode: assert property (p_lock_mode) else $error("locked mode changed");
  property p_unl_done; $changed(WRITE_UNLOCKED) |-> FRAME_DONE; endproperty
  a_unl_done: assert property (p_unl_done) else $error("unlock moved off a frame");
  property p_proto_done; $changed(OUT_CFG.output_protocol) |-> FRAME_DONE; endproperty
  a_proto_done: assert property (p_proto_done) else $error("protocol moved off a frame");
  property p_len; s_settled |-> OUT_CFG.frame_len == len_exp; endproperty
  a_len: assert property (p_len) else $error("frame length wrong");
  property p_sec; s_settled |-> OUT_CFG.secondary_len == sec_exp; endproperty
  a_sec: assert property (p_sec) else $error("secondary length wrong");
endmodule
bind aspc_core aspc_core_chk #(.DATA_LEN(DATA_LEN)) u_chk (.CLK(CLK), .RST_N(RST_N), .CS_N(CS_N),
  .FORMAT_LEN(FORMAT_LEN), .WRITE_UNLOCKED(WRITE_UNLOCKED), .POWER_OFF(POWER_OFF), .OUT_CFG(OUT_CFG),
  .FRAME_DONE(FRAME_DONE));

// >>> aspc_host.sv
module aspc_host (
  output logic      sclk,
  output logic      cs_n,
  output logic      sdi,
  input  wire logic sdo
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] rd;
  initial begin
    sclk = 1'b0;
    cs_n = 1'b1;
    sdi  = 1'b0;
    rd   = 8'h00;
  end
  // The link clock stands still low between frames, so nothing is shifted outside them.
  task automatic xfer(input logic [23:0] f);
    cs_n = 1'b0;
    for (int i = 23; i >= 0; i--) begin
      sdi = f[i];
      #80 sclk = 1'b1;
      #80 sclk = 1'b0;
      if (i > 15) begin
        rd[i-16] = sdo;
      end
    end
    sdi = ~sdi;
    #80 cs_n = 1'b1;
  endtask
endmodule

// >>> aspc_core_tb_top.sv
module aspc_core_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  import aspc_pkg::*;
  logic         clk;
  logic         rst_n;
  logic         ce;
  logic         sclk;
  logic         cs_n;
  logic         sdi;
  logic         sdo_rd;
  logic         unl;
  logic         done;
  logic [5:0]   fmt;
  aspc_power_t  pwr;
  aspc_outcfg_t cfg;
  int           failures;
  int           checked;
  initial clk = 1'b0;
  always #25 clk = ~clk;
  aspc_host u_host (.sclk(sclk), .cs_n(cs_n), .sdi(sdi), .sdo(sdo_rd));
  aspc_core DUT (.CLK(clk), .RST_N(rst_n), .CE(ce), .SCLK(sclk), .CS_N(cs_n), .SDI(sdi), .FORMAT_LEN(fmt),
    .SDO_RD(sdo_rd), .WRITE_UNLOCKED(unl), .POWER_OFF(pwr), .OUT_CFG(cfg), .FRAME_DONE(done));
  task automatic wrap_up;
    $display("checked %0d failures %0d", checked, failures);
    if (failures == 0 && checked > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checked++;
    if (got !== exp) begin
      failures++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic frame(input logic [4:0] c, input logic [10:0] a, input logic [7:0] d);
    u_host.xfer({c, a, d});
    repeat (8) @(negedge clk);
  endtask
  task automatic rd(input logic [10:0] a, input logic [7:0] exp);
    frame(CMD_RD, a, 8'h00);
    frame(CMD_NOP, 11'h000, 8'h00);
    chk(u_host.rd, exp);
  endtask
  task automatic t_reset;
    chk({4'h0, pwr}, 8'h00);
    chk({6'h0, cfg.input_clock_mode}, 8'h00);
    chk({7'h0, unl}, 8'h00);
  endtask
  task automatic t_locked;
    frame(CMD_WR, ADDR_PWR, 8'h1E);
    frame(CMD_SET, ADDR_INP, 8'h03);
    frame(CMD_WR, ADDR_ACCESS, 8'h55);
    chk({4'h0, pwr}, 8'h00);
    chk({6'h0, cfg.input_clock_mode}, 8'h00);
    chk({7'h0, unl}, 8'h00);
    rd(ADDR_PWR, 8'h00);
  endtask
  task automatic t_power;
    frame(CMD_WR, ADDR_ACCESS, UNLOCK_KEY);
    chk({7'h0, unl}, 8'h01);
    for (int i = 1; i < 5; i++) begin
      frame(CMD_WR, ADDR_PWR, 8'h01 << i);
      chk({4'h0, pwr}, 8'h01 << (i - 1));
    end
    frame(CMD_SET, ADDR_PWR, 8'h0E);
    frame(CMD_CLR, ADDR_PWR, 8'h02);
    chk({4'h0, pwr}, 8'h0E);
    rd(ADDR_PWR, 8'h1C);
  endtask
  task automatic t_inp;
    for (int m = 3; m >= 0; m--) begin
      frame(CMD_WR, ADDR_INP, 8'(m));
      chk({6'h0, cfg.input_clock_mode}, 8'(m));
    end
    rd(ADDR_INP, 8'h00);
  endtask
  task automatic t_ce;
    ce = 1'b0;
    frame(CMD_WR, ADDR_INP, 8'h01);
    chk({6'h0, cfg.input_clock_mode}, 8'h00);
    ce = 1'b1;
    repeat (8) @(negedge clk);
    chk({6'h0, cfg.input_clock_mode}, 8'h01);
  endtask
  task automatic t_outp;
    logic [7:0] tv [8][5];
    tv = '{'{8'h14, 8'h00, 8'h14, 8'h00, 8'h00}, '{8'h0C, 8'h40, 8'h10, 8'h00, 8'h40},
           '{8'h14, 8'h60, 8'h20, 8'h00, 8'h60}, '{8'h0C, 8'h54, 8'h10, 8'h08, 8'h54},
           '{8'h14, 8'h54, 8'h20, 8'h10, 8'h54}, '{8'h14, 8'h44, 8'h20, 8'h10, 8'h44},
           '{8'h14, 8'h14, 8'h14, 8'h0A, 8'h04}, '{8'h14, 8'h07, 8'h14, 8'h0A, 8'h07}};
    for (int i = 0; i < 8; i++) begin
      fmt = tv[i][0][5:0];
      frame(CMD_WR, ADDR_OUTP, tv[i][1]);
      chk({2'h0, cfg.frame_len}, tv[i][2]);
      chk({2'h0, cfg.secondary_len}, tv[i][3]);
      chk({1'b0, cfg.processor_friendly_output, cfg.right_aligned, cfg.lane_split_by_byte, 1'b0,
           cfg.dual_lane_output, cfg.output_protocol}, tv[i][4]);
    end
    rd(ADDR_OUTP, 8'h07);
  endtask
  initial begin
    failures = 0;
    checked = 0;
    rst_n = 1'b0;
    ce = 1'b1;
    fmt = 6'h10;
    repeat (10) @(negedge clk);
    rst_n = 1'b1;
    repeat (2) @(negedge clk);
    t_reset;
    t_locked;
    t_power;
    t_inp;
    t_ce;
    t_outp;
    wrap_up;
  end
  initial begin
    #3000000;
    failures++;
    wrap_up;
  end
endmodule
